/* File: core/ctte_addr_gen.v */
/*
 * effective address former for every operand mode,
 * plus the relative branch target.
 * assumes offset bytes arrive already fetched.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ctte_defs.vh"
module ctte_addr_gen (
    input wire [3:0] mode_i,
    input wire [15:0] hx_i,
    input wire [15:0] sp_i,
    input wire [7:0] hi_i,
    input wire [7:0] lo_i,
    input wire [15:0] pc_i,
    output reg [15:0] ea_o,
    output reg postinc_o,
    output wire [15:0] br_tgt_o
);
// ----------------------------------------
// address per mode
// ----------------------------------------
wire [15:0] w16; // two-byte field, high first
assign w16 = {hi_i, lo_i};
// branch: offset is a signed byte
assign br_tgt_o = pc_i + {{8{lo_i[7]}}, lo_i}; // [RQ17]
always @* begin
    ea_o = {8'h00, lo_i};
    postinc_o = 1'b0;
    case (mode_i)
        `CTTE_M_DIR: ea_o = {8'h00, lo_i}; // [RQ13]
        `CTTE_M_IX: ea_o = hx_i;
        `CTTE_M_XOFS8: ea_o = hx_i + {8'h00, lo_i};
        `CTTE_M_SOFS8: ea_o = sp_i + {8'h00, lo_i}; // [RQ12]
        `CTTE_M_XOFS16: ea_o = hx_i + w16; // [RQ11]
        `CTTE_M_SOFS16: ea_o = sp_i + w16; // [RQ12]
        `CTTE_M_FULL: ea_o = w16; // [RQ13]
        `CTTE_M_XINC: begin
            ea_o = hx_i; // [RQ9]
            postinc_o = 1'b1;
        end
        `CTTE_M_XOFS8INC: begin
            ea_o = hx_i + {8'h00, lo_i}; // [RQ10]
            postinc_o = 1'b1;
        end
        // destination page byte follows the immediate
        `CTTE_M_IMM2PG: ea_o = {8'h00, lo_i}; // [RQ14]
        `CTTE_M_PG2XINC: begin
            ea_o = hx_i; // [RQ15]
            postinc_o = 1'b1;
        end
        `CTTE_M_XINC2PG: begin
            ea_o = hx_i; // [RQ16]
            postinc_o = 1'b1;
        end
        default: ea_o = {8'h00, lo_i};
    endcase
end
endmodule
`default_nettype wire

/* File: core/ctte_exec.v */
/*
 * executor for the software trap, register transfers
 * and the negative/zero check, one bus cycle per clock.
 * assumes memory answers combinationally: read data for
 * the address on mem_addr_o is valid in the same cycle.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ctte_defs.vh"
// Summary of operation
// RQ1: trap pushes pc, index, acc, flags; vectors
// RQ2: trap is one byte, nine cycles, sets mask
// RQ3: check subtracts zero, clears overflow, sets N Z
// RQ4: check cycles 3,1,3,2,4 by mode
// RQ5: stack/index pair transfers with +1/-1, two cycles
// RQ6: acc-to-flags two cycles; others one cycle
// RQ7: index-low-to-acc one byte, one cycle
// RQ8: index pair is high:low; X means low
// RQ9: post-increment mode addresses by index pair
// RQ10: offset8 post-increment adds unsigned offset
// RQ11: offset16 fetched high byte first
// RQ12: stack modes add 8/16-bit offset to stack
// RQ13: full address two bytes; page one byte
// RQ14: immediate source written to page location
// RQ15: page source written via index pair
// RQ16: index pair source written to page
// RQ17: branch adds offset to program counter
// RQ18: counter pushed as separate high, low bytes
module ctte_exec #(
    parameter [15:0] RST_PC = `CTTE_RST_PC,
    parameter [15:0] VEC_HI = `CTTE_VEC_HI
) (
    input wire mclk_i,
    input wire arst_n_i,
    input wire [7:0] mem_rdata_i,
    output wire [15:0] mem_addr_o,
    output wire [7:0] mem_wdata_o,
    output wire mem_wr_o,
    output wire mem_rd_o,
    output wire [7:0] acc_o,
    output wire [15:0] idx_o,
    output wire [15:0] sp_o,
    output wire [15:0] pc_o,
    output wire [7:0] flags_o,
    output wire done_o
);
// ----------------------------------------
// states
// ----------------------------------------
localparam [2:0] S_FETCH = 3'h0; // opcode cycle
localparam [2:0] S_PRE = 3'h1; // opcode after prefix
localparam [2:0] S_OPB = 3'h2; // operand byte fetch
localparam [2:0] S_READ = 3'h3; // operand read
localparam [2:0] S_EX2 = 3'h4; // second inherent cycle
localparam [2:0] S_TRAP = 3'h5; // trap sequence
// ----------------------------------------
// registers
// ----------------------------------------
reg [2:0] st_ff, nxt_st;
reg [7:0] acc_ff, nxt_acc; // accumulator
reg [15:0] hx_ff, nxt_hx; // index pair high:low
reg [15:0] sp_ff, nxt_sp; // stack pointer
reg [15:0] pc_ff, nxt_pc; // program counter
reg [7:0] fl_ff, nxt_fl; // flag register
reg [7:0] op_ff, nxt_op; // held opcode
reg [3:0] mode_ff, nxt_mode; // operand mode
reg [2:0] step_ff, nxt_step; // trap step
reg [15:0] addr_ff, nxt_addr;
reg [7:0] wd_ff, nxt_wd;
reg wr_ff, nxt_wr;
reg rd_ff, nxt_rd;
reg done_ff, nxt_done;
// ----------------------------------------
// helpers
// ----------------------------------------
wire [15:0] pc_inc; // next sequential counter
wire [15:0] ea; // operand address
wire ea_postinc; // mode bumps index pair
wire [15:0] br_tgt; // unused branch target
wire chk_n; // check result negative
wire chk_z; // check result zero
reg [7:0] chk_val; // byte under check
assign pc_inc = pc_ff + 16'h0001;
// pick the byte the check looks at
always @* begin
    chk_val = mem_rdata_i;
    if (st_ff == S_FETCH && mem_rdata_i == `CTTE_OP_NZC_A) begin
        chk_val = acc_ff;
    end else if (st_ff == S_FETCH && mem_rdata_i == `CTTE_OP_NZC_X) begin
        chk_val = hx_ff[7:0]; // [RQ8]
    end
end
// address former, offset byte straight from the bus
ctte_addr_gen u_addr (
    .mode_i(mode_ff),
    .hx_i(hx_ff),
    .sp_i(sp_ff),
    .hi_i(8'h00),
    .lo_i(mem_rdata_i),
    .pc_i(pc_ff),
    .ea_o(ea),
    .postinc_o(ea_postinc),
    .br_tgt_o(br_tgt)
);
// negative/zero evaluation
ctte_nz_flags u_nz (
    .val_i(chk_val),
    .neg_o(chk_n),
    .zero_o(chk_z)
);
// ----------------------------------------
// next-state logic
// ----------------------------------------
always @* begin
    nxt_st = st_ff;
    nxt_acc = acc_ff;
    nxt_hx = hx_ff;
    nxt_sp = sp_ff;
    nxt_pc = pc_ff;
    nxt_fl = fl_ff;
    nxt_op = op_ff;
    nxt_mode = mode_ff;
    nxt_step = step_ff;
    nxt_addr = addr_ff;
    nxt_wd = wd_ff;
    nxt_wr = 1'b0;
    nxt_rd = 1'b1;
    nxt_done = 1'b0;
    case (st_ff)
        // opcode on the bus, one-cycle work done here
        S_FETCH: begin
            nxt_op = mem_rdata_i;
            nxt_pc = pc_inc;
            nxt_addr = pc_inc;
            case (mem_rdata_i)
                `CTTE_OP_TRAP: begin
                    // push counter low byte first [RQ1]
                    nxt_st = S_TRAP;
                    nxt_step = 3'h0;
                    nxt_addr = sp_ff;
                    nxt_wd = pc_inc[7:0]; // [RQ18]
                    nxt_wr = 1'b1;
                    nxt_rd = 1'b0;
                end
                `CTTE_OP_A2F, `CTTE_OP_S2HX, `CTTE_OP_HX2S: begin
                    nxt_st = S_EX2; // [RQ5] [RQ6]
                end
                `CTTE_OP_F2A: begin
                    nxt_acc = fl_ff; // [RQ6]
                    nxt_done = 1'b1;
                end
                `CTTE_OP_A2X: begin
                    nxt_hx = {hx_ff[15:8], acc_ff}; // [RQ6] [RQ8]
                    nxt_done = 1'b1;
                end
                `CTTE_OP_X2A: begin
                    nxt_acc = hx_ff[7:0]; // [RQ7]
                    nxt_done = 1'b1;
                end
                `CTTE_OP_NZC_A, `CTTE_OP_NZC_X: begin
                    // inherent check, one cycle [RQ4]
                    nxt_fl[`CTTE_F_V] = 1'b0; // [RQ3]
                    nxt_fl[`CTTE_F_N] = chk_n;
                    nxt_fl[`CTTE_F_Z] = chk_z;
                    nxt_done = 1'b1;
                end
                `CTTE_OP_NZC_PG: begin
                    nxt_st = S_OPB; // [RQ4]
                    nxt_mode = `CTTE_M_DIR;
                end
                `CTTE_OP_NZC_XOFS: begin
                    nxt_st = S_OPB; // [RQ4]
                    nxt_mode = `CTTE_M_XOFS8;
                end
                `CTTE_OP_NZC_XPTR: begin
                    // operand straight from index pair
                    nxt_st = S_READ; // [RQ4]
                    nxt_mode = `CTTE_M_IX;
                    nxt_addr = hx_ff;
                end
                `CTTE_OP_PREFIX: begin
                    nxt_st = S_PRE;
                end
                default: begin
                    // unknown opcode: skipped as a no-op
                    nxt_done = 1'b1;
                end
            endcase
        end
        // second opcode byte after the prefix
        S_PRE: begin
            nxt_op = mem_rdata_i;
            nxt_pc = pc_inc;
            nxt_addr = pc_inc;
            if (mem_rdata_i == `CTTE_OP_NZC_XOFS) begin
                nxt_st = S_OPB; // [RQ4]
                nxt_mode = `CTTE_M_SOFS8;
            end else begin
                // unsupported prefixed opcode: no-op
                nxt_st = S_FETCH;
                nxt_done = 1'b1;
            end
        end
        // offset or page byte on the bus
        S_OPB: begin
            nxt_pc = pc_inc;
            nxt_addr = ea; // [RQ12] [RQ13]
            nxt_st = S_READ;
        end
        // memory operand on the bus
        S_READ: begin
            nxt_fl[`CTTE_F_V] = 1'b0; // [RQ3]
            nxt_fl[`CTTE_F_N] = chk_n;
            nxt_fl[`CTTE_F_Z] = chk_z;
            if (ea_postinc) begin
                nxt_hx = hx_ff + 16'h0001; // [RQ9]
            end
            nxt_addr = pc_ff;
            nxt_st = S_FETCH;
            nxt_done = 1'b1;
        end
        // second cycle of two-cycle inherents
        S_EX2: begin
            case (op_ff)
                `CTTE_OP_A2F: begin
                    nxt_fl = acc_ff | `CTTE_F_ONES; // [RQ6]
                end
                `CTTE_OP_S2HX: begin
                    nxt_hx = sp_ff + 16'h0001; // [RQ5]
                end
                `CTTE_OP_HX2S: begin
                    nxt_sp = hx_ff - 16'h0001; // [RQ5]
                end
                default: begin
                    nxt_fl = fl_ff;
                end
            endcase
            nxt_addr = pc_ff;
            nxt_st = S_FETCH;
            nxt_done = 1'b1;
        end
        // trap: pushes, mask set, vector fetch [RQ2]
        S_TRAP: begin
            nxt_step = step_ff + 3'h1;
            nxt_rd = 1'b0;
            case (step_ff)
                3'h0, 3'h1, 3'h2, 3'h3: begin
                    // one byte per cycle, stack moves down [RQ1]
                    nxt_sp = sp_ff - 16'h0001;
                    nxt_addr = sp_ff - 16'h0001;
                    nxt_wr = 1'b1;
                    if (step_ff == 3'h0) begin
                        nxt_wd = pc_ff[15:8]; // [RQ18]
                    end else if (step_ff == 3'h1) begin
                        nxt_wd = hx_ff[7:0];
                    end else if (step_ff == 3'h2) begin
                        nxt_wd = acc_ff;
                    end else begin
                        nxt_wd = fl_ff;
                    end
                end
                3'h4: begin
                    // last push done, stack moves past it
                    nxt_sp = sp_ff - 16'h0001; // [RQ1]
                end
                3'h5: begin
                    // only the mask changes [RQ2]
                    nxt_fl[`CTTE_F_I] = 1'b1; // [RQ1]
                    nxt_addr = VEC_HI;
                    nxt_rd = 1'b1;
                end
                3'h6: begin
                    nxt_pc = {mem_rdata_i, pc_ff[7:0]}; // [RQ18]
                    nxt_addr = VEC_HI + 16'h0001;
                    nxt_rd = 1'b1;
                end
                default: begin
                    nxt_pc = {pc_ff[15:8], mem_rdata_i}; // [RQ1]
                    nxt_addr = {pc_ff[15:8], mem_rdata_i};
                    nxt_rd = 1'b1;
                    nxt_st = S_FETCH;
                    nxt_done = 1'b1;
                end
            endcase
        end
        default: begin
            nxt_st = S_FETCH;
            nxt_addr = pc_ff;
        end
    endcase
end
// ----------------------------------------
// state registers
// ----------------------------------------
always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        st_ff <= S_FETCH;
        acc_ff <= 8'h00;
        hx_ff <= 16'h0000;
        sp_ff <= `CTTE_RST_SP;
        pc_ff <= RST_PC;
        fl_ff <= `CTTE_RST_FLAGS;
        op_ff <= 8'h00;
        mode_ff <= `CTTE_M_DIR;
        step_ff <= 3'h0;
        addr_ff <= RST_PC;
        wd_ff <= 8'h00;
        wr_ff <= 1'b0;
        rd_ff <= 1'b1;
        done_ff <= 1'b0;
    end else begin
        st_ff <= nxt_st;
        acc_ff <= nxt_acc;
        hx_ff <= nxt_hx;
        sp_ff <= nxt_sp;
        pc_ff <= nxt_pc;
        fl_ff <= nxt_fl;
        op_ff <= nxt_op;
        mode_ff <= nxt_mode;
        step_ff <= nxt_step;
        addr_ff <= nxt_addr;
        wd_ff <= nxt_wd;
        wr_ff <= nxt_wr;
        rd_ff <= nxt_rd;
        done_ff <= nxt_done;
    end
end
// ----------------------------------------
// outputs, all straight from flops
// ----------------------------------------
assign mem_addr_o = addr_ff;
assign mem_wdata_o = wd_ff;
assign mem_wr_o = wr_ff;
assign mem_rd_o = rd_ff;
assign acc_o = acc_ff;
assign idx_o = hx_ff;
assign sp_o = sp_ff;
assign pc_o = pc_ff;
assign flags_o = fl_ff;
assign done_o = done_ff;
endmodule
`default_nettype wire

/* File: core/ctte_nz_flags.v */
/*
 * negative/zero test of one byte (byte minus zero, no store).
 * assumes a pure combinational use by the executor.
 */
`timescale 1ns/10ps
`default_nettype none
module ctte_nz_flags (
    input wire [7:0] val_i,
    output wire neg_o,
    output wire zero_o
);
// ----------------------------------------
// subtract zero and look at the result
// ----------------------------------------
wire [7:0] diff; // result of byte minus zero
assign diff = val_i - 8'h00; // [RQ3]
assign neg_o = diff[7];
assign zero_o = (diff == 8'h00);
endmodule
`default_nettype wire

/* File: shared/ctte_defs.vh */
/*
 * constants for the trap, transfer and test executor:
 * opcodes, flag bit positions, reset values and mode codes.
 * assumes it is included by bare name from core files.
 */
`ifndef CTTE_DEFS_VH
`define CTTE_DEFS_VH
// ----------------------------------------
// opcodes
// ----------------------------------------
`define CTTE_OP_TRAP 8'h83
`define CTTE_OP_A2F 8'h84
`define CTTE_OP_F2A 8'h85
`define CTTE_OP_A2X 8'h97
`define CTTE_OP_X2A 8'h9F
`define CTTE_OP_S2HX 8'h95
`define CTTE_OP_HX2S 8'h94
`define CTTE_OP_NZC_PG 8'h3D
`define CTTE_OP_NZC_A 8'h4D
`define CTTE_OP_NZC_X 8'h5D
`define CTTE_OP_NZC_XOFS 8'h6D
`define CTTE_OP_NZC_XPTR 8'h7D
`define CTTE_OP_PREFIX 8'h9E
// ----------------------------------------
// flag register layout and reset values
// ----------------------------------------
`define CTTE_F_V 7
`define CTTE_F_H 4
`define CTTE_F_I 3
`define CTTE_F_N 2
`define CTTE_F_Z 1
`define CTTE_F_C 0
`define CTTE_F_ONES 8'h60
`define CTTE_RST_FLAGS 8'h68
`define CTTE_RST_SP 16'h00FF
`define CTTE_RST_PC 16'h0000
`define CTTE_VEC_HI 16'hFFFC
// ----------------------------------------
// operand addressing mode codes
// ----------------------------------------
`define CTTE_M_DIR 4'h0
`define CTTE_M_IX 4'h1
`define CTTE_M_XOFS8 4'h2
`define CTTE_M_SOFS8 4'h3
`define CTTE_M_XOFS16 4'h4
`define CTTE_M_SOFS16 4'h5
`define CTTE_M_FULL 4'h6
`define CTTE_M_XINC 4'h7
`define CTTE_M_XOFS8INC 4'h8
`define CTTE_M_IMM2PG 4'h9
`define CTTE_M_PG2XINC 4'hA
`define CTTE_M_XINC2PG 4'hB
// ----------------------------------------
// last trap step number after the opcode
// ----------------------------------------
`define CTTE_TRAP_LAST 3'h7
`endif

/* File: verif/cpu_trap_transfer_test_exec_test.sv */
/*
 * self-checking bench: runs a short program and checks each instruction.
 * assumes the memory model answers every bus cycle with no wait.
 */
`timescale 1ns/10ps
`default_nettype none
module cpu_trap_transfer_test_exec_test;
    // ----------------------------------------
    // signals and tables
    // ----------------------------------------
    logic mclk_i;
    logic arst_n_i;
    wire [7:0] rdata, wdata, acc, flags;
    wire [15:0] addr, idx, sp, pc;
    wire wr, rd, done;
    int failures;
    int samples_checked;
    // cycles, next fetch, acc, index pair, stack, flags after each step
    logic [71:0] exp_tab [0:15] = '{
        72'h02_0001_00_0000_00FF_60, 72'h01_0002_00_0000_00FF_62, 72'h09_0100_00_0000_00FA_6A,
        72'h02_0101_00_00FB_00FA_6A, 72'h01_0102_FB_00FB_00FA_6A, 72'h02_0103_FB_00FB_00FA_FB,
        72'h01_0104_FB_00FB_00FA_7D, 72'h01_0105_7D_00FB_00FA_7D, 72'h01_0106_7D_007D_00FA_7D,
        72'h01_0107_7D_007D_00FA_79, 72'h02_0108_7D_007D_00FA_7D, 72'h03_010A_7D_007D_00FA_7B,
        72'h03_010C_7D_007D_00FA_7D, 72'h04_010F_7D_007D_00FA_79, 72'h02_0110_7D_007D_007C_79,
        72'h01_0111_7D_007D_007C_79};
    logic [7:0] code0 [0:2] = '{8'h84, 8'h4D, 8'h83}; // program at reset address
    logic [7:0] code1 [0:16] = '{8'h95, 8'h9F, 8'h84, 8'h4D, 8'h85, 8'h97, 8'h5D, 8'h7D, 8'h6D,
        8'h05, 8'h3D, 8'h90, 8'h9E, 8'h6D, 8'h01, 8'h94, 8'h00}; // program behind the vector
    logic [7:0] stk_exp [0:4] = '{8'h03, 8'h00, 8'h00, 8'h00, 8'h62}; // trap frame from 00FF down

    ctte_exec u_dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .mem_rdata_i(rdata), .mem_addr_o(addr),
        .mem_wdata_o(wdata), .mem_wr_o(wr), .mem_rd_o(rd), .acc_o(acc), .idx_o(idx), .sp_o(sp),
        .pc_o(pc), .flags_o(flags), .done_o(done));
    ctte_mem_model u_mem (.mclk_i(mclk_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    // compare one value, count it, report a mismatch
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // write one byte into memory
    task automatic put(input logic [15:0] a, input logic [7:0] d);
        u_mem.mem[a] = d;
    endtask

    // run one instruction to the next fetch and check its outcome
    task automatic step(input logic [71:0] e);
        logic [15:0] n;
        n = 16'h0000;
        do begin
            @(posedge mclk_i);
            #1;
            n = n + 16'h0001;
        end while (done !== 1'b1 && n < 16'h0014);
        chk(n, {8'h00, e[71:64]});
        chk(addr, e[63:48]);
        chk(pc, e[63:48]);
        chk({8'h00, acc}, {8'h00, e[47:40]});
        chk(idx, e[39:24]);
        chk(sp, e[23:8]);
        chk({8'h00, flags}, {8'h00, e[7:0]});
    endtask

    // print counts and verdict, then stop
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // clock, sequence, watchdog
    // ----------------------------------------
    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end

    // load program and data under reset, then walk the program
    initial begin
        failures = 0;
        samples_checked = 0;
        arst_n_i = 1'b0;
        repeat (16) @(posedge mclk_i);
        for (int i = 0; i < 3; i++) begin
            put(16'(i), code0[i]);
        end
        for (int i = 0; i < 17; i++) begin
            put(16'h0100 + 16'(i), code1[i]);
        end
        put(16'hFFFC, 8'h01);
        put(16'hFFFD, 8'h00);
        put(16'h007D, 8'h80);
        put(16'h0082, 8'h00);
        put(16'h0090, 8'hFF);
        #1 arst_n_i = 1'b1;
        for (int i = 0; i < 16; i++) begin
            step(exp_tab[i]);
        end
        for (int i = 0; i < 5; i++) begin
            chk({8'h00, u_mem.mem[16'h00FF - 16'(i)]}, {8'h00, stk_exp[i]});
        end
        end_of_test;
    end

    // cut a hang short well after the program should have ended
    initial begin : watchdog
        repeat (400) @(posedge mclk_i);
        failures++;
        end_of_test;
    end
endmodule
`default_nettype wire

/* File: verif/ctte_exec_asserts.sv */
/*
 * bus and register timing checks for the executor.
 * assumes done_o marks every opcode fetch after the first.
 */
`timescale 1ns/10ps
`default_nettype none
module ctte_exec_asserts #(
    parameter [15:0] VEC_HI = 16'hFFFC
) (
    input wire mclk_i,
    input wire arst_n_i,
    input wire [7:0] mem_rdata_i,
    input wire [15:0] mem_addr_o,
    input wire [7:0] mem_wdata_o,
    input wire mem_wr_o,
    input wire mem_rd_o,
    input wire [7:0] acc_o,
    input wire [15:0] idx_o,
    input wire [15:0] sp_o,
    input wire [7:0] flags_o,
    input wire done_o
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    wire [7:0] x_lo = idx_o[7:0]; // index low byte
    wire acc_neg = acc_o[7]; // accumulator sign
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);

    // ----------------------------------------
    // trap
    // ----------------------------------------
    a_trap_writes: assert property (done_o && mem_rdata_i == 8'h83 |=> mem_wr_o [*5] ##1 !mem_wr_o && !mem_rd_o)
        else $error("trap push count wrong");
    a_trap_stack: assert property (done_o && mem_rdata_i == 8'h83 |=> mem_addr_o == $past(sp_o) ##2
        mem_wdata_o == $past(x_lo, 3) ##1 mem_wdata_o == $past(acc_o, 4) ##1
        mem_wdata_o == $past(flags_o, 5) && mem_addr_o == $past(sp_o, 5) - 16'h0004)
        else $error("trap push order wrong");
    a_trap_vector: assert property (done_o && mem_rdata_i == 8'h83 |-> ##7 mem_rd_o && mem_addr_o == VEC_HI ##1
        mem_addr_o == VEC_HI + 16'h0001 ##1 done_o && sp_o == $past(sp_o, 9) - 16'h0005)
        else $error("trap vector fetch wrong");
    a_trap_flags: assert property (done_o && mem_rdata_i == 8'h83 |-> ##9 flags_o[3] &&
        (flags_o & 8'hF7) == ($past(flags_o, 9) & 8'hF7))
        else $error("trap flag change wrong");

    // ----------------------------------------
    // negative/zero check
    // ----------------------------------------
    a_check_acc: assert property (done_o && mem_rdata_i == 8'h4D |=> done_o && !flags_o[7] &&
        flags_o[2] == $past(acc_neg) && flags_o[1] == ($past(acc_o) == 8'h00) &&
        (flags_o & 8'h19) == ($past(flags_o) & 8'h19))
        else $error("accumulator check wrong");
    a_check_page: assert property (done_o && mem_rdata_i == 8'h3D |=> !done_o ##1 mem_rd_o &&
        mem_addr_o == {8'h00, $past(mem_rdata_i)} ##1 done_o)
        else $error("page check wrong");
    a_check_offset: assert property (done_o && mem_rdata_i == 8'h6D |=> ##1
        mem_addr_o == idx_o + {8'h00, $past(mem_rdata_i)} ##1 done_o)
        else $error("offset check wrong");
    a_check_stack: assert property (done_o && mem_rdata_i == 8'h9E ##1 mem_rdata_i == 8'h6D |=> ##1
        mem_addr_o == sp_o + {8'h00, $past(mem_rdata_i)} ##1 done_o)
        else $error("stack check wrong");

    // ----------------------------------------
    // transfers
    // ----------------------------------------
    a_tap_flags: assert property (done_o && mem_rdata_i == 8'h84 |=> !done_o ##1 done_o &&
        flags_o == ($past(acc_o, 2) | 8'h60))
        else $error("acc to flags wrong");
    a_sp_to_idx: assert property (done_o && mem_rdata_i == 8'h95 |=> !done_o ##1 done_o &&
        idx_o == $past(sp_o, 2) + 16'h0001 && flags_o == $past(flags_o, 2))
        else $error("stack to index wrong");
    a_idx_to_sp: assert property (done_o && mem_rdata_i == 8'h94 |=> !done_o ##1 done_o &&
        sp_o == $past(idx_o, 2) - 16'h0001 && flags_o == $past(flags_o, 2))
        else $error("index to stack wrong");
    a_one_xfer: assert property (done_o && (mem_rdata_i == 8'h85 || mem_rdata_i == 8'h97 ||
        mem_rdata_i == 8'h9F) |=> done_o && $stable(flags_o))
        else $error("single transfer wrong");

    c_trap: cover property (done_o && mem_rdata_i == 8'h83);
    c_stack_check: cover property (done_o && mem_rdata_i == 8'h9E);
    c_tap: cover property (done_o && mem_rdata_i == 8'h84);
endmodule
bind ctte_exec ctte_exec_asserts #(.VEC_HI(VEC_HI)) u_chk (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .mem_rdata_i(mem_rdata_i), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_wr_o(mem_wr_o),
    .mem_rd_o(mem_rd_o), .acc_o(acc_o), .idx_o(idx_o), .sp_o(sp_o), .flags_o(flags_o), .done_o(done_o));
`default_nettype wire

/* File: verif/ctte_mem_model.sv */
/*
 * program and data memory model facing the executor's bus.
 * assumes one bus cycle per clock: reads answer combinationally,
 * writes land at the rising edge that ends the write cycle.
 */
`timescale 1ns/10ps
`default_nettype none
module ctte_mem_model (
    input wire logic mclk_i,
    input wire logic [15:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o
);
    // ----------------------------------------
    // storage
    // ----------------------------------------
    logic [7:0] mem [0:65535]; // whole 64k space
    logic [7:0] last_ff; // last byte handed out

    // memory starts cleared
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'h00;
        end
        last_ff = 8'h00;
    end

    // released bus shows the inverse of the last read, never a stale match
    assign rdata_o = rd_i ? mem[addr_i] : ~last_ff;

    // write strobe stores, read strobe remembers the byte shown
    always @(posedge mclk_i) begin
        if (wr_i) begin
            mem[addr_i] <= wdata_i;
        end
        if (rd_i) begin
            last_ff <= mem[addr_i];
        end
    end
endmodule
`default_nettype wire
